// File: sbi_consts.svh
// Constants for the bank interrupt and auto precharge logic of the SDRAM core.
// Assumes a single 125 MHz clock; every timing count is derived from it here.
`ifndef SBI_CONSTS_SVH
`define SBI_CONSTS_SVH

// Clock rate and documented-style timings in their own units.
`define SBI_CLK_MHZ       125
`define SBI_WR_NS         15
`define SBI_RP_NS         20

// Least times round up to whole cycles and never fall below one cycle.
`define SBI_WR_CYC_RAW    ((`SBI_WR_NS * `SBI_CLK_MHZ + 999) / 1000)
`define SBI_WR_CYC        ((`SBI_WR_CYC_RAW < 1) ? 1 : `SBI_WR_CYC_RAW)
`define SBI_RP_CYC_RAW    ((`SBI_RP_NS * `SBI_CLK_MHZ + 999) / 1000)
`define SBI_RP_CYC        ((`SBI_RP_CYC_RAW < 1) ? 1 : `SBI_RP_CYC_RAW)
`define SBI_CNT_W         4

// Address field positions.
`define SBI_AP_BIT        10
`define SBI_CL_MSB        6
`define SBI_CL_LSB        4
`define SBI_BL_MSB        2
`define SBI_BL_LSB        0
`define SBI_COL_MSB       7

// Mode setting codes and reset values.
`define SBI_CL_CODE2      3'h2
`define SBI_CL_CODE3      3'h3
`define SBI_CL3_RESET     1'h1
`define SBI_BLMASK_RESET  8'h00
`define SBI_FULLPAGE_CODE 3'h7

`endif

// File: sbi_pkg.sv
// Types shared by the SDRAM bank interrupt logic: command pins, commands, bank states.
// Assumes command pins are sampled on the same clock that runs the core.
package sbi_pkg;

	// Command pins travel together.
	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
	} sbi_pins_t;

	typedef enum {
		SBI_NOP,
		SBI_ACT,
		SBI_RD,
		SBI_WR,
		SBI_PRE,
		SBI_BST,
		SBI_REF,
		SBI_LMR
	} sbi_cmd_t;

	typedef enum {
		SBI_IDLE,
		SBI_ACTIVE,
		SBI_RD_AP,
		SBI_WR_AP,
		SBI_WR_REC,
		SBI_PRECH
	} sbi_bank_state_t;

	// One data beat of a burst, naming its bank and column.
	typedef struct packed {
		logic       valid;
		logic [1:0] bank;
		logic [7:0] col;
	} sbi_beat_t;

	// Decodes the four command pins into a command.
	function automatic sbi_cmd_t sbi_decode(input sbi_pins_t p);
		sbi_cmd_t c;
		c = SBI_NOP;
		if (!p.cs_n) begin
			case ({p.ras_n, p.cas_n, p.we_n})
				3'h5:    c = SBI_RD;
				3'h4:    c = SBI_WR;
				3'h3:    c = SBI_ACT;
				3'h2:    c = SBI_PRE;
				3'h6:    c = SBI_BST;
				3'h1:    c = SBI_REF;
				3'h0:    c = SBI_LMR;
				default: c = SBI_NOP;
			endcase
		end
		return c;
	endfunction

endpackage

// File: sbi_mem.sv
// Data array of the SDRAM core: four banks of 256 columns of 16 bits.
// Assumes one write and one read per cycle; read data come from a register.
module sbi_mem (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        we,
	input  wire logic [9:0]  waddr,
	input  wire logic [15:0] wdata,
	input  wire logic [1:0]  wbe,
	input  wire logic [9:0]  raddr,
	output logic      [15:0] rdata
);

	logic [15:0] mem [0:1023];

	// Byte lanes are written separately so the mask can protect either half.
	always_ff @(posedge clk) begin
		if (we && wbe[0]) begin
			mem[waddr][7:0] <= wdata[7:0];
		end
		if (we && wbe[1]) begin
			mem[waddr][15:8] <= wdata[15:8];
		end
	end

	// Read data is registered, which gives the output path its first pipeline stage.
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata <= 16'h0000;
		end else begin
			rdata <= mem[raddr];
		end
	end

endmodule

// File: sbi_bank.sv
// State of one bank: open row, auto precharge pending, write recovery and precharge.
// Assumes the burst engine reports interruptions and natural burst ends as pulses.
`include "sbi_consts.svh"

module sbi_bank (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic act,
	input  wire logic pre,
	input  wire logic start,
	input  wire logic ap,
	input  wire logic wr,
	input  wire logic interrupt,
	input  wire logic done,
	output logic      idle,
	output logic      precharging
);

	sbi_pkg::sbi_bank_state_t state;
	logic [`SBI_CNT_W-1:0]    cnt;

	localparam logic [`SBI_CNT_W-1:0] WR_LOAD = `SBI_CNT_W'(`SBI_WR_CYC - 1);
	localparam logic [`SBI_CNT_W-1:0] RP_LOAD = `SBI_CNT_W'(`SBI_RP_CYC - 1);

	// Bank sequencing; an interrupted auto precharge burst precharges on its own.
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= sbi_pkg::SBI_IDLE;
			cnt   <= '0;
		end else begin
			case (state)
				sbi_pkg::SBI_IDLE: begin
					if (act) begin
						state <= sbi_pkg::SBI_ACTIVE;
					end
				end
				sbi_pkg::SBI_ACTIVE: begin
					if (pre) begin
						state <= sbi_pkg::SBI_PRECH;
						cnt   <= RP_LOAD;
					end else if (start && ap && done && !wr) begin
						state <= sbi_pkg::SBI_PRECH;
						cnt   <= RP_LOAD;
					end else if (start && ap && done) begin
						state <= sbi_pkg::SBI_WR_REC;
						cnt   <= WR_LOAD;
					end else if (start && ap) begin
						state <= wr ? sbi_pkg::SBI_WR_AP : sbi_pkg::SBI_RD_AP;
					end
				end
				sbi_pkg::SBI_RD_AP: begin
					// Precharge starts at the edge that registers the other bank's command.
					if (interrupt || done) begin // RL1 RL6 RL9
						state <= sbi_pkg::SBI_PRECH;
						cnt   <= RP_LOAD;
					end
				end
				sbi_pkg::SBI_WR_AP: begin
					// Recovery is counted from the interrupting command, not from the last data.
					if (interrupt || done) begin // RL1 RL10 RL11
						state <= sbi_pkg::SBI_WR_REC;
						cnt   <= WR_LOAD;
					end
				end
				sbi_pkg::SBI_WR_REC: begin
					if (cnt == '0) begin // RL10 RL11
						state <= sbi_pkg::SBI_PRECH;
						cnt   <= RP_LOAD;
					end else begin
						cnt <= cnt - 1'b1;
					end
				end
				sbi_pkg::SBI_PRECH: begin
					if (cnt == '0) begin
						state <= sbi_pkg::SBI_IDLE;
					end else begin
						cnt <= cnt - 1'b1;
					end
				end
				default: begin
					state <= sbi_pkg::SBI_IDLE;
				end
			endcase
		end
	end

	assign idle        = (state == sbi_pkg::SBI_IDLE);
	assign precharging = (state == sbi_pkg::SBI_PRECH);

endmodule

// File: sbi_core.sv
// Burst engine of a four bank SDRAM core with bank interruption and concurrent auto precharge.
// Assumes the controller drives command, address, mask and write data on CLOCK itself,
// so those inputs need no synchroniser; the data pin is split into in, out and enables.
//
// Operation
// RL1 - Interrupted auto precharge burst precharges its bank without a precharge command.
// RL2 - Commands to other banks that are not reads or writes leave bursts running.
// RL3 - Read after read: old output stops, new data follows, one CAS latency later.
// RL4 - Write interrupts plain read at its edge; mask one clock before it.
// RL5 - Write interrupts auto precharge read at its edge; mask two clocks before.
// RL6 - Auto precharge read cut by write precharges at that write's edge.
// RL7 - Read cuts write at its edge; last write word is the one before.
// RL8 - Write cuts write at its edge; old bank takes no further data.
// RL9 - Auto precharge read cut by read precharges at the new read's edge.
// RL10 - Auto precharge write cut by read precharges after write recovery from that edge.
// RL11 - Auto precharge write cut by write precharges after write recovery from that edge.
// RL12 - Commands decode from chip select, row, column strobes and write enable.
// RL13 - Refresh and mode load are issued only while all banks are idle.
// RL14 - CAS latency comes from the current mode setting, two or three clocks.
`include "sbi_consts.svh"

module sbi_core (
	input  wire logic                CLOCK,
	input  wire logic                RST,
	input  wire sbi_pkg::sbi_pins_t  CMD,
	input  wire logic [1:0]          BA,
	input  wire logic [11:0]         ADDR,
	input  wire logic [1:0]          DQM,
	input  wire logic [15:0]         DQ_IN,
	output logic      [15:0]         DQ_OUT,
	output logic      [1:0]          DQ_OE,
	output logic      [3:0]          BANK_IDLE,
	output logic      [3:0]          BANK_PRECHARGING
);

	sbi_pkg::sbi_cmd_t cmd;
	logic              is_rw;
	logic              is_wr_cmd;
	logic              ap;

	// Mode setting.
	logic              cl3;
	logic [7:0]        bl_mask;
	logic              full_page;

	// Running burst.
	logic              b_act;
	logic [1:0]        b_bank;
	logic              b_wr;
	logic              b_ap;
	logic [7:0]        b_col;
	logic [7:0]        b_left;

	// Beat taken at this edge.
	sbi_pkg::sbi_beat_t beat;
	logic               beat_wr;
	logic               last_beat;

	// Read pipeline and output mask.
	sbi_pkg::sbi_beat_t pipe0;
	sbi_pkg::sbi_beat_t pipe1;
	sbi_pkg::sbi_beat_t rsel;
	logic [1:0]         dqm_d1;

	logic [3:0]         bank_act;
	logic [3:0]         bank_pre;
	logic [3:0]         bank_start;
	logic [3:0]         bank_int;
	logic [3:0]         bank_done;

	// Steps a column inside its burst boundary, wrapping like a sequential burst.
	function automatic logic [7:0] next_col(input logic [7:0] col, input logic [7:0] mask);
		logic [7:0] inc;
		inc = col + 8'h01;
		return (col & ~mask) | (inc & mask);
	endfunction

	// Command decode straight from the pins.
	always_comb begin
		cmd       = sbi_pkg::sbi_decode(CMD); // RL12
		is_rw     = (cmd == sbi_pkg::SBI_RD) || (cmd == sbi_pkg::SBI_WR); // RL12
		is_wr_cmd = (cmd == sbi_pkg::SBI_WR);
		ap        = ADDR[`SBI_AP_BIT];
	end

	// Mode setting is loaded on any mode load command, with no check that all banks idle, so a running burst can see it change.
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			cl3       <= `SBI_CL3_RESET;
			bl_mask   <= `SBI_BLMASK_RESET;
			full_page <= 1'h0;
		end else if (cmd == sbi_pkg::SBI_LMR) begin // RL13
			if (ADDR[`SBI_CL_MSB:`SBI_CL_LSB] == `SBI_CL_CODE2) begin
				cl3 <= 1'h0; // RL14
			end else if (ADDR[`SBI_CL_MSB:`SBI_CL_LSB] == `SBI_CL_CODE3) begin
				cl3 <= 1'h1; // RL14
			end
			case (ADDR[`SBI_BL_MSB:`SBI_BL_LSB])
				3'h0: begin
					bl_mask   <= 8'h00;
					full_page <= 1'h0;
				end
				3'h1: begin
					bl_mask   <= 8'h01;
					full_page <= 1'h0;
				end
				3'h2: begin
					bl_mask   <= 8'h03;
					full_page <= 1'h0;
				end
				3'h3: begin
					bl_mask   <= 8'h07;
					full_page <= 1'h0;
				end
				`SBI_FULLPAGE_CODE: begin
					bl_mask   <= 8'hFF;
					full_page <= 1'h1;
				end
				default: begin
					bl_mask   <= bl_mask;
					full_page <= full_page;
				end
			endcase
		end
	end

	// The beat of this edge: a new read or write takes over at once, else the burst goes on.
	always_comb begin
		beat      = '0;
		beat_wr   = 1'h0;
		last_beat = 1'h0;
		if (is_rw) begin // RL7 RL8
			beat.valid = 1'h1;
			beat.bank  = BA;
			beat.col   = ADDR[`SBI_COL_MSB:0];
			beat_wr    = is_wr_cmd;
			last_beat  = (bl_mask == 8'h00) && !full_page;
		end else if (b_act) begin // RL2
			beat.valid = 1'h1;
			beat.bank  = b_bank;
			beat.col   = b_col;
			beat_wr    = b_wr;
			last_beat  = !full_page && (b_left == 8'h01);
		end
	end

	// Burst bookkeeping; a read or write to any bank replaces the running burst.
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			b_act  <= 1'h0;
			b_bank <= 2'h0;
			b_wr   <= 1'h0;
			b_ap   <= 1'h0;
			b_col  <= 8'h00;
			b_left <= 8'h00;
		end else if (is_rw) begin // RL3 RL4 RL5 RL7 RL8
			b_act  <= (bl_mask != 8'h00) || full_page;
			b_bank <= BA;
			b_wr   <= is_wr_cmd;
			b_ap   <= ap;
			b_col  <= next_col(ADDR[`SBI_COL_MSB:0], bl_mask);
			b_left <= bl_mask;
		end else if (cmd == sbi_pkg::SBI_BST) begin
			b_act <= 1'h0;
		end else if (cmd == sbi_pkg::SBI_PRE && (ap || BA == b_bank)) begin
			b_act <= 1'h0;
		end else if (b_act) begin // RL2
			b_col <= next_col(b_col, bl_mask);
			if (!full_page) begin
				b_left <= b_left - 8'h01;
				b_act  <= (b_left != 8'h01);
			end
		end
	end

	// Per bank event pulses; only reads and writes to another bank raise a bank's interrupt pulse.
	always_comb begin
		for (int b = 0; b < 4; b++) begin
			bank_act[b]   = (cmd == sbi_pkg::SBI_ACT) && (BA == 2'(b));
			bank_pre[b]   = (cmd == sbi_pkg::SBI_PRE) && (ap || BA == 2'(b));
			bank_start[b] = is_rw && (BA == 2'(b));
			bank_int[b]   = b_act && (b_bank == 2'(b)) && is_rw && (BA != 2'(b)); // RL1 RL2
			bank_done[b]  = beat.valid && last_beat && (beat.bank == 2'(b));
		end
	end

	// One tracker per bank holds auto precharge and recovery timing.
	for (genvar g = 0; g < 4; g++) begin : g_bank
		sbi_bank u_bank (
			.clk         (CLOCK),
			.rst         (RST),
			.act         (bank_act[g]),
			.pre         (bank_pre[g]),
			.start       (bank_start[g]),
			.ap          (ap),
			.wr          (is_wr_cmd),
			.interrupt   (bank_int[g]),
			.done        (bank_done[g]),
			.idle        (BANK_IDLE[g]),
			.precharging (BANK_PRECHARGING[g])
		);
	end

	// Read beats enter the pipeline at their edge; a write flushes beats still in flight.
	always_ff @(posedge CLOCK) begin
		if (RST || is_wr_cmd) begin // RL4 RL5
			pipe0 <= '0;
			pipe1 <= '0;
		end else begin
			pipe0       <= beat;
			pipe0.valid <= beat.valid && !beat_wr;
			pipe1       <= pipe0;
		end
	end

	// The stage that feeds the array sets the latency; old beats drain first, then new.
	always_comb begin
		rsel = cl3 ? pipe1 : pipe0; // RL3 RL14
	end

	// The mask is delayed so that it blanks output two clocks after it is sampled.
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			dqm_d1 <= 2'h0;
		end else begin
			dqm_d1 <= DQM;
		end
	end

	// Output enables drop at a write edge so the controller's data never meets ours.
	always_ff @(posedge CLOCK) begin
		if (RST || is_wr_cmd) begin // RL4 RL5
			DQ_OE <= 2'h0;
		end else begin
			DQ_OE <= {2{rsel.valid}} & ~dqm_d1; // RL3
		end
	end

	// Write beats are taken with the mask applied per byte; a cut burst writes nothing more.
	sbi_mem u_mem (
		.clk   (CLOCK),
		.rst   (RST),
		.we    (beat.valid && beat_wr), // RL7 RL8 RL10 RL11
		.waddr ({beat.bank, beat.col}),
		.wdata (DQ_IN),
		.wbe   (~DQM),
		.raddr ({rsel.bank, rsel.col}),
		.rdata (DQ_OUT)
	);

endmodule

// File: sbi_core_assertions.sv
// Checker for the bank interrupt core, watching only the core's ports.
// Assumes one clock, synchronous reset, and the core's reset mode of CL3 and burst length 1.
module sbi_core_assertions (
	input wire logic               CLOCK,
	input wire logic               RST,
	input wire sbi_pkg::sbi_pins_t CMD,
	input wire logic [1:0]         BA,
	input wire logic [11:0]        ADDR,
	input wire logic [1:0]         DQM,
	input wire logic [15:0]        DQ_IN,
	input wire logic [15:0]        DQ_OUT,
	input wire logic [1:0]         DQ_OE,
	input wire logic [3:0]         BANK_IDLE,
	input wire logic [3:0]         BANK_PRECHARGING
);
	logic       rd;
	logic       wr;
	logic       quiet;
	logic [2:0] cl;
	logic [2:0] bl;

	// Quiet means no command cuts the read burst and no byte is masked.
	assign rd = 4'(CMD) == 4'h5;
	assign wr = 4'(CMD) == 4'h4;
	assign quiet = !(rd || wr || 4'(CMD) == 4'h2 || 4'(CMD) == 4'h6) && DQM == 2'h0;

	// Latency and burst code as last loaded; unknown codes are ignored, as in the core.
	always_ff @(posedge CLOCK) begin
		if (RST)
			cl <= 3'h3;
		else if (4'(CMD) == 4'h0 && (ADDR[6:4] == 3'h2 || ADDR[6:4] == 3'h3))
			cl <= ADDR[6:4];
	end

	// A burst of one beat is never cut, so interruption checks need a longer burst.
	always_ff @(posedge CLOCK) begin
		if (RST)
			bl <= 3'h0;
		else if (4'(CMD) == 4'h0 && (ADDR[2:0] < 3'h4 || ADDR[2:0] == 3'h7))
			bl <= ADDR[2:0];
	end

	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST);

	rst_vals_a: assert property ($past(RST) |-> DQ_OE == 2'h0 && BANK_IDLE == 4'hF
		&& BANK_PRECHARGING == 4'h0) else $error("outputs not at reset values");
	wr_cut_a: assert property (wr |=> DQ_OE == 2'h0)
		else $error("read still driven after a write");
	rdap_pre_a: assert property (rd && BA == 2'h0 && ADDR[10] && bl != 3'h0
		##1 (rd || wr) && BA != 2'h0 |=> BANK_PRECHARGING[0]) else $error("no precharge on cut");
	wrap_rec_a: assert property (wr && BA == 2'h0 && ADDR[10] && bl != 3'h0
		##1 (rd || wr) && BA != 2'h0 |=> !BANK_PRECHARGING[0] ##1 !BANK_PRECHARGING[0]
		##1 BANK_PRECHARGING[0]) else $error("write recovery wrong");
	pre_len_a: assert property ($rose(BANK_PRECHARGING[0])
		|-> BANK_PRECHARGING[0] [*3] ##1 BANK_IDLE[0]) else $error("precharge length wrong");
	cl3_lat_a: assert property (rd && cl == 3'h3 ##1 quiet [*2] |=> DQ_OE == 2'h3)
		else $error("CL3 data late");
	cl2_lat_a: assert property (rd && cl == 3'h2 && DQM == 2'h0 ##1 quiet |=> DQ_OE == 2'h3)
		else $error("CL2 data late");
	pre_all_a: assert property (4'(CMD) == 4'h2 && ADDR[10]
		|=> (BANK_IDLE | BANK_PRECHARGING) == 4'hF) else $error("precharge all missed a bank");
	act_open_a: assert property (4'(CMD) == 4'h3 && BA == 2'h1 |=> !BANK_IDLE[1])
		else $error("activate left bank idle");

	cover property (rd ##1 rd && BA != $past(BA));
	cover property (wr ##1 rd && BA != $past(BA));
	cover property ($rose(BANK_PRECHARGING[3]));
endmodule

// File: sbi_ctl_model.sv
// Controller model: drives command pins, bank, address, byte mask and write data.
// Assumes callers enter its tasks just after a rising clock edge.
module sbi_ctl_model (
	input  wire logic          clk,
	output sbi_pkg::sbi_pins_t cmd,
	output logic [1:0]         ba,
	output logic [11:0]        addr,
	output logic [1:0]         dqm,
	output logic [15:0]        dq
);
	timeunit 1ns;
	timeprecision 1ps;

	// Pins start deselected so nothing is taken before the first command.
	initial begin
		cmd = 4'hF;
		ba = 2'h0;
		addr = 12'h000;
		dqm = 2'h0;
		dq = 16'h0000;
	end

	// Holds one command and its qualifiers until the edge that takes it.
	task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
		input logic [1:0] m, input logic [15:0] d);
		cmd = c;
		ba = b;
		addr = a;
		dqm = m;
		dq = d;
		@(posedge clk);
		#1;
	endtask

	// Idle cycles; the released data bus flips so stale data never looks valid.
	task automatic idle(input int n);
		cmd = 4'h7;
		dqm = 2'h0;
		dq = ~dq;
		repeat (n) begin
			@(posedge clk);
			#1;
		end
	endtask
endmodule

// File: tb_sdram_bank_interrupt_autoprecharge.sv
// Self-checking bench for the bank interrupt core with a controller model.
// Assumes the core's reset mode and its 2 cycle recovery, 3 cycle precharge.
module tb_sdram_bank_interrupt_autoprecharge;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [3:0] c_rd = 4'h5, c_wr = 4'h4, c_act = 4'h3, c_pre = 4'h2, c_nop = 4'h7;
	logic               clk;
	logic               rst;
	sbi_pkg::sbi_pins_t cmd;
	logic [1:0]         ba, dqm, dq_oe;
	logic [11:0]        addr;
	logic [15:0]        dq_drv, dq_wire, dq_out;
	logic [3:0]         idle, prech;
	int                 err_count = 0;
	int                 n_tests = 0;
	logic [25:0]        rows [5] = '{{2'h0, 8'h00, 16'hA000}, {2'h1, 8'h00, 16'hB001},
		{2'h1, 8'h01, 16'hE004}, {2'h0, 8'h0A, 16'hC002}, {2'h2, 8'h0A, 16'hD003}};
	logic [25:0]        backs [5] = '{{2'h0, 8'h08, 16'h1F00}, {2'h0, 8'h09, 16'h1F01},
		{2'h0, 8'h0A, 16'hC002}, {2'h3, 8'h08, 16'h3D00}, {2'h3, 8'h09, 16'h3D01}};

	// The shared data wire carries the core's word on each byte lane it enables.
	assign dq_wire = {dq_oe[1] ? dq_out[15:8] : dq_drv[15:8], dq_oe[0] ? dq_out[7:0] : dq_drv[7:0]};

	sbi_ctl_model u_ctl (.clk(clk), .cmd(cmd), .ba(ba), .addr(addr), .dqm(dqm), .dq(dq_drv));
	sbi_core u_dut (.CLOCK(clk), .RST(rst), .CMD(cmd), .BA(ba), .ADDR(addr), .DQM(dqm),
		.DQ_IN(dq_wire), .DQ_OUT(dq_out), .DQ_OE(dq_oe), .BANK_IDLE(idle),
		.BANK_PRECHARGING(prech));

	// Free running 125 MHz clock.
	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic op(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
		input logic [1:0] m, input logic [15:0] d);
		u_ctl.issue(c, b, a, m, d);
	endtask

	task automatic results();
		$display("Comparisons %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Cuts a hang short; the whole run needs about 120 cycles.
	initial begin
		#20000;
		err_count++;
		results();
	end

	// Main sequence: table of plain write and read backs, then the interruption cases.
	initial begin
		rst = 1'h1;
		repeat (20) @(posedge clk);
		#1;
		check({dq_oe, idle, prech, 6'h00}, {2'h0, 4'hF, 4'h0, 6'h00});
		rst = 1'h0;
		u_ctl.idle(2);
		foreach (rows[i]) begin
			op(c_act, rows[i][25:24], 12'h000, 2'h0, 16'h0000);
			op(c_wr, rows[i][25:24], {4'h0, rows[i][23:16]}, 2'h0, rows[i][15:0]);
			op(c_rd, rows[i][25:24], {4'h0, rows[i][23:16]}, 2'h0, 16'h0000);
			u_ctl.idle(2);
			check(dq_out, rows[i][15:0]);
		end
		op(c_pre, 2'h0, 12'h400, 2'h0, 16'h0000);
		u_ctl.idle(4);
		check(16'(idle), 16'h000F);
		op(4'h0, 2'h0, 12'h032, 2'h0, 16'h0000);
		u_ctl.idle(2);
		op(c_act, 2'h0, 12'h000, 2'h0, 16'h0000);
		op(c_act, 2'h1, 12'h000, 2'h0, 16'h0000);
		op(c_act, 2'h3, 12'h000, 2'h0, 16'h0000);
		// Auto precharge read cut by a read to another bank.
		op(c_rd, 2'h0, 12'h400, 2'h0, 16'h0000);
		op(c_rd, 2'h1, 12'h000, 2'h0, 16'h0000);
		check(16'(prech[0]), 16'h0001);
		u_ctl.idle(1);
		check(dq_out, 16'hA000);
		u_ctl.idle(1);
		check(dq_out, 16'hB001);
		op(c_act, 2'h2, 12'h000, 2'h0, 16'h0000);
		check(dq_out, 16'hE004);
		check(16'(idle[0]), 16'h0001);
		u_ctl.idle(3);
		// Auto precharge read cut by an auto precharge write, which a read then cuts.
		op(c_rd, 2'h2, 12'h40A, 2'h0, 16'h0000);
		op(c_nop, 2'h0, 12'h000, 2'h3, 16'h0000);
		op(c_nop, 2'h0, 12'h000, 2'h3, 16'h0000);
		op(c_wr, 2'h3, 12'h408, 2'h0, 16'h3D00);
		check(16'(dq_oe), 16'h0000);
		check(16'(prech[2]), 16'h0001);
		op(c_nop, 2'h0, 12'h000, 2'h0, 16'h3D01);
		op(c_rd, 2'h1, 12'h000, 2'h0, 16'h0000);
		check(16'(prech[3]), 16'h0000);
		u_ctl.idle(2);
		check(16'(prech[3]), 16'h0001);
		check(dq_out, 16'hB001);
		u_ctl.idle(6);
		// Auto precharge write cut by a write to another bank.
		op(c_act, 2'h0, 12'h000, 2'h0, 16'h0000);
		op(c_wr, 2'h0, 12'h408, 2'h0, 16'h1F00);
		op(c_nop, 2'h0, 12'h000, 2'h0, 16'h1F01);
		op(c_wr, 2'h1, 12'h008, 2'h0, 16'h2A00);
		op(c_nop, 2'h0, 12'h000, 2'h0, 16'h2A01);
		u_ctl.idle(8);
		op(c_pre, 2'h0, 12'h400, 2'h0, 16'h0000);
		u_ctl.idle(4);
		op(4'h0, 2'h0, 12'h020, 2'h0, 16'h0000);
		u_ctl.idle(2);
		foreach (backs[i]) begin
			op(c_act, backs[i][25:24], 12'h000, 2'h0, 16'h0000);
			op(c_rd, backs[i][25:24], {4'h0, backs[i][23:16]}, 2'h0, 16'h0000);
			u_ctl.idle(1);
			check(dq_out, backs[i][15:0]);
		end
		results();
	end
endmodule

bind sbi_core sbi_core_assertions u_chk (.CLOCK(CLOCK), .RST(RST), .CMD(CMD), .BA(BA),
	.ADDR(ADDR), .DQM(DQM), .DQ_IN(DQ_IN), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE),
	.BANK_IDLE(BANK_IDLE), .BANK_PRECHARGING(BANK_PRECHARGING));
